/* adc_ctrl_pkg.sv */
// Package with constants shared by the converter control block.
// Assumes a single 20 MHz system clock drives every file that imports it.
package adc_ctrl_pkg;
	localparam int          SAMPLE_WIDTH     = 14;
	localparam int          PIPE_LATENCY     = 4;
	localparam int          CAL_SLOTS        = 4;
	localparam int          CAL_DIVIDE       = 2;
	localparam int          CAL_TRIM_WIDTH   = 8;
	localparam int          CAL_SETTLE_CYC   = 64;
	localparam int          FIFO_WORDS       = 4;
	localparam int          FIFO_WIDTH       = SAMPLE_WIDTH + 1;
	localparam logic [13:0] CODE_SIGN_FLIP   = 14'h2000;
	localparam logic [13:0] CODE_MAX_POS     = 14'h1fff;
	localparam logic [13:0] CODE_MAX_NEG     = 14'h2000;
	localparam logic        DONE_RESET_LEVEL = 1'b1;

	typedef enum logic [2:0] {
		CAL_IDLE    = 3'b001,
		CAL_MEASURE = 3'b010,
		CAL_STORE   = 3'b100
	} cal_state_t;
endpackage

/* sample_stream_if.sv */
// Interface carrying result words between the core and the output FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface sample_stream_if #(parameter int WIDTH = 15);
	logic [WIDTH-1:0] data;
	logic             valid;
	logic             ready;

	modport source (output data, output valid, input ready);
	modport sink   (input data, input valid, output ready);
endinterface

/* sample_fifo.sv */
// Small FIFO buffering result words on their way to the output bus.
// Assumes one clock; read data come from a register.
`timescale 1ns/1ns
module sample_fifo #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 4
) (
	input  wire logic             sys_clk,
	input  wire logic             reset,
	sample_stream_if.sink         in_port,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	// Refuses depths that the pointer logic cannot serve.
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("sample_fifo depth must be a power of two, two or more");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
	logic [WIDTH-1:0] out_q, out_d;
	logic             ov_q, ov_d;
	logic             full, empty, push, pop, take;

	// Full and empty come from comparing the pointers and their extra wrap bit.
	assign full          = (wr_q[AW] != rd_q[AW]) &&
	                       (wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign empty         = (wr_q == rd_q);
	assign in_port.ready = !full;
	assign push          = in_port.valid && !full;
	assign take          = !ov_q || out_ready;
	assign pop           = take && !empty;
	assign out_data      = out_q;
	assign out_valid     = ov_q;

	// Next pointers and output register.
	always_comb begin
		wr_d  = wr_q + (AW+1)'(push);
		rd_d  = rd_q + (AW+1)'(pop);
		out_d = pop ? mem_q[rd_q[AW-1:0]] : out_q;
		ov_d  = take ? !empty : ov_q;
	end

	// Registers only.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wr_q  <= '0;
			rd_q  <= '0;
			out_q <= '0;
			ov_q  <= 1'b0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			out_q <= out_d;
			ov_q  <= ov_d;
		end
	end

	// Storage has no reset; words are written only when pushed.
	always_ff @(posedge sys_clk) begin
		if (push)
			mem_q[wr_q[AW-1:0]] <= in_port.data;
	end
endmodule

/* adc_cal_output_ctrl.sv */
// Digital control of a pipelined converter: clock divider, calibration, output.
// Assumes raw quantizer codes arrive on sys_clk; start request is asynchronous.
//
// Operation
// RULE1: Each result reaches the bus exactly four sampling periods after sampling; the code adds three clocks of FIFO delay after the four-stage pipeline.
// RULE2: Sampling clock is the input clock divided by two.
// RULE3: Host keeps the clock running throughout calibration.
// RULE4: Host holds start high four to about 17,400 clocks, then low.
// RULE5: Start request is asynchronous and is synchronised before use.
// RULE6: Done output falls one or two clocks after start is seen.
// RULE7: Done rises when calibration ends; conversions then resume.
// RULE8: Calibration measures stage mismatch, stores it, applies it to conversions.
// RULE9: Analog inputs are ignored while calibration runs.
// RULE10: Output enable low floats data and range bits; high drives them.
// RULE11: Results are two's complement, most significant bit is sign.
// RULE12: A valid strobe marks each result word for capture.
// RULE13: Start requests during calibration are ignored until done returns high.
`timescale 1ns/1ns
module adc_cal_output_ctrl
	import adc_ctrl_pkg::*;
#(
	parameter int WIDTH      = SAMPLE_WIDTH,
	parameter int LATENCY    = PIPE_LATENCY,
	parameter int SETTLE_CYC = CAL_SETTLE_CYC
) (
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire logic             cal_start_request,
	input  wire logic             output_enable,
	input  wire logic [WIDTH-1:0] analog_in_pos,
	input  wire logic [WIDTH-1:0] analog_in_neg,
	input  wire logic [CAL_SLOTS*CAL_TRIM_WIDTH-1:0] stage_error,
	output logic                  sample_clk,
	output logic                  cal_done,
	output logic      [WIDTH-1:0] sample_code_bus,
	output logic      [WIDTH-1:0] sample_code_oe,
	output logic                  over_range_bit,
	output logic                  over_range_oe,
	output logic                  sample_valid_strobe
);
	// Refuses parameter values that the logic cannot serve.
	if (WIDTH != SAMPLE_WIDTH) begin : g_bad_width
		$error("adc_cal_output_ctrl width must match the package");
	end
	if (LATENCY < 1 || SETTLE_CYC < 1) begin : g_bad_count
		$error("latency and settle count must be positive");
	end

	// Decodes one slot's trim from the packed stage error inputs.
	function automatic logic [CAL_TRIM_WIDTH-1:0] slot_trim(
		input logic [CAL_SLOTS*CAL_TRIM_WIDTH-1:0] vec,
		input int                                  idx
	);
		return vec[idx*CAL_TRIM_WIDTH +: CAL_TRIM_WIDTH];
	endfunction

	// Start request synchroniser, then edge detection on the second stage.
	logic start_meta_q, start_sync_q, start_prev_q;
	logic start_rise;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			start_meta_q <= 1'b0;
			start_sync_q <= 1'b0;
			start_prev_q <= 1'b0;
		end else begin
			start_meta_q <= cal_start_request; // RULE5
			start_sync_q <= start_meta_q; // RULE5
			start_prev_q <= start_sync_q;
		end
	end

	assign start_rise = start_sync_q && !start_prev_q;

	// Divide-by-two sampling clock; a phase bit marks each sample instant.
	logic div_q, div_d;

	always_comb begin
		div_d = !div_q; // RULE2
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset)
			div_q <= 1'b0;
		else
			div_q <= div_d;
	end

	assign sample_clk = div_q;

	// Calibration sequencer and on-chip trim memory.
	cal_state_t                    st_q, st_d;
	logic [$clog2(SETTLE_CYC)+1:0] cnt_q, cnt_d;
	logic [$clog2(CAL_SLOTS):0]    slot_q, slot_d;
	logic [CAL_TRIM_WIDTH-1:0]     trim_q [CAL_SLOTS];
	logic [CAL_TRIM_WIDTH-1:0]     trim_d [CAL_SLOTS];
	logic                          done_q, done_d;

	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		slot_d = slot_q;
		done_d = done_q;
		for (int i = 0; i < CAL_SLOTS; i++)
			trim_d[i] = trim_q[i];
		unique case (st_q)
		CAL_IDLE: begin
			if (start_rise) begin // RULE13
				st_d   = CAL_MEASURE;
				done_d = 1'b0; // RULE6
				cnt_d  = '0;
				slot_d = '0;
			end
		end
		CAL_MEASURE: begin
			if (cnt_q == ($clog2(SETTLE_CYC)+2)'(SETTLE_CYC - 1))
				st_d = CAL_STORE;
			else
				cnt_d = cnt_q + 1'b1;
		end
		CAL_STORE: begin
			trim_d[slot_q[$clog2(CAL_SLOTS)-1:0]] =
				slot_trim(stage_error, int'(slot_q)); // RULE8
			cnt_d = '0;
			if (slot_q == ($clog2(CAL_SLOTS)+1)'(CAL_SLOTS - 1)) begin
				st_d   = CAL_IDLE;
				done_d = 1'b1; // RULE7
			end else begin
				slot_d = slot_q + 1'b1;
				st_d   = CAL_MEASURE;
			end
		end
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st_q   <= CAL_IDLE;
			cnt_q  <= '0;
			slot_q <= '0;
			done_q <= DONE_RESET_LEVEL;
			for (int i = 0; i < CAL_SLOTS; i++)
				trim_q[i] <= '0;
		end else begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			slot_q <= slot_d;
			done_q <= done_d;
			for (int i = 0; i < CAL_SLOTS; i++)
				trim_q[i] <= trim_d[i];
		end
	end

	assign cal_done = done_q;

	// Corrected two's complement result from the differential input pair.
	logic signed [WIDTH+1:0] diff_raw, corr_sum;
	logic signed [WIDTH+1:0] corr_total;
	logic [WIDTH-1:0]        code_now;
	logic                    over_now;

	always_comb begin
		corr_total = '0;
		for (int i = 0; i < CAL_SLOTS; i++)
			corr_total = corr_total +
				(WIDTH+2)'(signed'(trim_q[i])); // RULE8
		diff_raw = (WIDTH+2)'(analog_in_pos) - (WIDTH+2)'(analog_in_neg);
		corr_sum = (diff_raw >>> 1) - corr_total;
		over_now = 1'b0;
		if (corr_sum > (WIDTH+2)'(signed'({1'b0, CODE_MAX_POS}))) begin
			code_now = CODE_MAX_POS;
			over_now = 1'b1;
		end else if (corr_sum <
				-(WIDTH+2)'(signed'({1'b0, CODE_MAX_NEG}))) begin
			code_now = CODE_MAX_NEG;
			over_now = 1'b1;
		end else begin
			code_now = corr_sum[WIDTH-1:0]; // RULE11
		end
	end

	// Pipeline of results, advancing once per sampling period.
	logic [WIDTH:0] pipe_q [LATENCY];
	logic [WIDTH:0] pipe_d [LATENCY];
	logic [LATENCY-1:0] pv_q, pv_d;
	logic           sample_tick;

	assign sample_tick = !div_q;

	always_comb begin
		for (int i = 0; i < LATENCY; i++) begin
			pipe_d[i] = pipe_q[i];
			pv_d[i]   = pv_q[i];
		end
		if (sample_tick) begin
			pipe_d[0] = {over_now, code_now};
			pv_d[0]   = done_q; // RULE9
			for (int i = 1; i < LATENCY; i++) begin
				pipe_d[i] = pipe_q[i-1]; // RULE1
				pv_d[i]   = pv_q[i-1];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pv_q <= '0;
			for (int i = 0; i < LATENCY; i++)
				pipe_q[i] <= '0;
		end else begin
			pv_q <= pv_d;
			for (int i = 0; i < LATENCY; i++)
				pipe_q[i] <= pipe_d[i];
		end
	end

	// Output FIFO drained once per sampling period.
	sample_stream_if #(.WIDTH(FIFO_WIDTH)) stream ();
	logic [WIDTH:0] fifo_data;
	logic           fifo_valid, fifo_ready;

	assign stream.data  = pipe_q[LATENCY-1];
	assign stream.valid = pv_q[LATENCY-1] && sample_tick;
	assign fifo_ready   = div_q;

	sample_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_WORDS)
	) u_fifo (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.in_port   (stream.sink),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_ready)
	);

	// Output bus registers and data valid strobe.
	logic [WIDTH:0] bus_q, bus_d;
	logic           dv_q, dv_d;

	always_comb begin
		bus_d = bus_q;
		dv_d  = 1'b0;
		if (fifo_valid && fifo_ready) begin
			bus_d = fifo_data;
			dv_d  = 1'b1; // RULE12
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			bus_q <= '0;
			dv_q  <= 1'b0;
		end else begin
			bus_q <= bus_d;
			dv_q  <= dv_d;
		end
	end

	// Drivers float when output enable is low.
	assign sample_code_bus     = bus_q[WIDTH-1:0];
	assign over_range_bit      = bus_q[WIDTH];
	assign sample_code_oe      = {WIDTH{output_enable}}; // RULE10
	assign over_range_oe       = output_enable; // RULE10
	assign sample_valid_strobe = dv_q;
endmodule

/* adc_cal_output_ctrl_checker.sv */
// Port checker for the converter control block.
// Assumes it is bound to each instance of the top module.
`timescale 1ns/1ns
module adc_ctrl_checker
	import adc_ctrl_pkg::*;
#(
	parameter int WIDTH      = SAMPLE_WIDTH,
	parameter int LATENCY    = PIPE_LATENCY,
	parameter int SETTLE_CYC = CAL_SETTLE_CYC
) (
	input wire logic             sys_clk,
	input wire logic             reset,
	input wire logic             cal_start_request,
	input wire logic             output_enable,
	input wire logic             sample_clk,
	input wire logic             cal_done,
	input wire logic [WIDTH-1:0] sample_code_bus,
	input wire logic [WIDTH-1:0] sample_code_oe,
	input wire logic             over_range_oe,
	input wire logic             sample_valid_strobe
);
	logic [31:0] low_q;
	logic [31:0] low_d;

	// Counts the clocks spent with calibration running.
	always_comb begin
		low_d = cal_done ? 32'h0 : low_q + 32'h1;
	end
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			low_q <= 32'h0;
		end else begin
			low_q <= low_d;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	clk_half_a: assert property (!$past(reset) |-> sample_clk != $past(sample_clk))
		else $error("sample clock missed a toggle");
	done_fall_a: assert property ($rose(cal_start_request) && cal_done && low_q == 32'h0 |-> ##[3:4] !cal_done)
		else $error("done did not fall after start");
	cal_length_a: assert property ($rose(cal_done) |-> low_q == CAL_SLOTS * (SETTLE_CYC + 1))
		else $error("calibration length wrong");
	done_keep_a: assert property ($rose(cal_done) |=> cal_done [*2])
		else $error("calibration restarted too soon");
	strobe_pulse_a: assert property (sample_valid_strobe |=> !sample_valid_strobe)
		else $error("strobe longer than one clock");
	oe_follow_a: assert property (sample_code_oe == {WIDTH{output_enable}} && over_range_oe == output_enable)
		else $error("output enables do not follow input");
	bus_hold_a: assert property ($changed(sample_code_bus) |-> sample_valid_strobe)
		else $error("bus changed without strobe");
	cal_quiet_a: assert property (low_q > 4 * LATENCY |-> !sample_valid_strobe)
		else $error("word produced during calibration");
endmodule

bind adc_cal_output_ctrl adc_ctrl_checker #(
	.WIDTH(WIDTH), .LATENCY(LATENCY), .SETTLE_CYC(SETTLE_CYC)
) checker_inst (
	.sys_clk(sys_clk), .reset(reset), .cal_start_request(cal_start_request),
	.output_enable(output_enable), .sample_clk(sample_clk),
	.cal_done(cal_done), .sample_code_bus(sample_code_bus),
	.sample_code_oe(sample_code_oe), .over_range_oe(over_range_oe),
	.sample_valid_strobe(sample_valid_strobe)
);

/* acq_host_model.sv */
// Host model: commands calibration and captures result words.
// Assumes it shares the converter clock.
`timescale 1ns/1ns
module acq_host_model #(
	parameter int WIDTH = 14
) (
	input  wire logic             sys_clk,
	input  wire logic             cal_cmd,
	input  wire logic [15:0]      hold_cyc,
	input  wire logic             sample_valid_strobe,
	input  wire logic [WIDTH-1:0] sample_code_bus,
	input  wire logic             over_range_bit,
	output logic                  cal_start_request = 1'b0,
	output logic                  word_seen = 1'b0,
	output logic      [WIDTH:0]   word_q
);
	logic [15:0] left_q = 16'h0;

	// Start pulse lasts hold_cyc clocks; the model does not limit hold_cyc to 4 to 17,400.
	always @(posedge sys_clk) begin
		if (cal_cmd) begin
			cal_start_request <= 1'b1;
			left_q            <= hold_cyc;
		end else if (left_q > 16'h1) begin
			left_q <= left_q - 16'h1;
		end else begin
			left_q            <= 16'h0;
			cal_start_request <= 1'b0;
		end
	end

	// Takes each word in the clock that the strobe marks.
	always @(posedge sys_clk) begin
		word_seen <= sample_valid_strobe;
		if (sample_valid_strobe) begin
			word_q <= {over_range_bit, sample_code_bus};
		end
	end
endmodule

/* test_adc_cal_output_ctrl.sv */
// Self-checking bench for the converter control block.
// Assumes the host model stands on the output side.
`timescale 1ns/1ns
module test_adc_cal_output_ctrl
	import adc_ctrl_pkg::*;
;
	logic        sys_clk       = 1'b0;
	logic        reset         = 1'b1;
	logic        output_enable = 1'b1;
	logic [13:0] analog_in_pos = 14'h0;
	logic [13:0] analog_in_neg = 14'h0;
	logic [31:0] stage_error   = 32'h0;
	logic        cal_cmd       = 1'b0;
	logic [15:0] hold_cyc      = 16'h6;
	logic        track         = 1'b0;
	wire         cal_start_request;
	wire         sample_clk;
	wire         cal_done;
	wire  [13:0] sample_code_bus;
	wire  [13:0] sample_code_oe;
	wire         over_range_bit;
	wire         over_range_oe;
	wire         sample_valid_strobe;
	wire         word_seen;
	wire  [14:0] word_q;
	logic [14:0] exp_q[$];
	int          num_errors  = 0;
	int          checks_done = 0;
	int          cycles      = 0;
	int          trim_sum    = 0;
	int          seed;

	adc_cal_output_ctrl #(.SETTLE_CYC(4)) DUT (
		.sys_clk(sys_clk), .reset(reset),
		.cal_start_request(cal_start_request), .output_enable(output_enable),
		.analog_in_pos(analog_in_pos), .analog_in_neg(analog_in_neg),
		.stage_error(stage_error), .sample_clk(sample_clk),
		.cal_done(cal_done), .sample_code_bus(sample_code_bus),
		.sample_code_oe(sample_code_oe), .over_range_bit(over_range_bit),
		.over_range_oe(over_range_oe),
		.sample_valid_strobe(sample_valid_strobe)
	);

	acq_host_model #(.WIDTH(14)) host (
		.sys_clk(sys_clk), .cal_cmd(cal_cmd), .hold_cyc(hold_cyc),
		.sample_valid_strobe(sample_valid_strobe),
		.sample_code_bus(sample_code_bus), .over_range_bit(over_range_bit),
		.cal_start_request(cal_start_request), .word_seen(word_seen),
		.word_q(word_q)
	);

	// Clock keeps running through calibration.
	always #25 sys_clk = ~sys_clk;

	// Halved input difference less the trims, clipped with the range bit.
	function automatic logic [14:0] expect_word(logic [13:0] p,
			logic [13:0] n, int t);
		int v;
		v = (int'(p) - int'(n)) / 2 - t;
		if (v > 8191)
			return {1'b1, CODE_MAX_POS};
		if (v < -8192)
			return {1'b1, CODE_MAX_NEG};
		return {1'b0, 14'(v)};
	endfunction

	// Sum of the four signed trim bytes stored by a calibration.
	function automatic int sum_trims(logic [31:0] v);
		int s;
		s = 0;
		for (int i = 0; i < CAL_SLOTS; i++)
			s += int'($signed(v[i*CAL_TRIM_WIDTH +: CAL_TRIM_WIDTH]));
		return s;
	endfunction

	// Even codes keep the halved difference exact.
	function automatic logic [13:0] rnd14();
		return 14'($urandom()) & 14'h3ffe;
	endfunction

	task automatic compare(input logic [14:0] seen, input logic [14:0] want);
		checks_done++;
		if (seen !== want) begin
			num_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic stop_test();
		if (num_errors == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic drive(input logic [13:0] p, input logic [13:0] n);
		@(posedge sys_clk);
		analog_in_pos <= p;
		analog_in_neg <= n;
		output_enable <= 1'($urandom());
	endtask

	// Requests calibration, optionally again while it runs.
	task automatic run_cal(input logic [15:0] hold, input logic again);
		track = 1'b0;
		stage_error <= $urandom();
		cal_cmd  <= 1'b1;
		hold_cyc <= hold;
		drive(rnd14(), rnd14());
		cal_cmd <= 1'b0;
		repeat (4) drive(rnd14(), rnd14());
		@(negedge sys_clk);
		compare({14'h0, cal_done}, 15'h0);
		repeat (5) drive(rnd14(), rnd14());
		cal_cmd <= again;
		drive(rnd14(), rnd14());
		cal_cmd <= 1'b0;
		repeat (12) drive(rnd14(), rnd14());
		@(negedge sys_clk);
		compare({14'h0, cal_done}, 15'h0);
		drive(rnd14(), rnd14());
		@(negedge sys_clk);
		compare({14'h0, cal_done}, 15'h1);
		exp_q.delete();
		trim_sum = sum_trims(stage_error);
		track = 1'b1;
		repeat (5) drive(rnd14(), rnd14());
		@(negedge sys_clk);
		compare({14'h0, cal_done}, 15'h1);
	endtask

	// Scoreboard: while track is set, queues what each sample tick takes while done is high and checks each word.
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles > 2000) begin
			num_errors++;
			stop_test();
		end
		if (track && !reset && !sample_clk && cal_done) begin
			exp_q.push_back(expect_word(analog_in_pos, analog_in_neg,
				trim_sum));
		end
		if (track && word_seen) begin
			compare(word_q, exp_q.size() > 0 ? exp_q.pop_front() : 15'h7fff);
		end
	end

	// Corner codes first, then random streams around two calibrations.
	initial begin
		seed = $urandom(41);
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		track = 1'b1;
		drive(14'h3ffe, 14'h0000);
		drive(14'h0000, 14'h3ffe);
		drive(14'h2000, 14'h2000);
		repeat (150) drive(rnd14(), rnd14());
		run_cal(16'd6, 1'b1);
		repeat (100) drive(rnd14(), rnd14());
		run_cal(16'd40, 1'b0);
		repeat (100) drive(rnd14(), rnd14());
		stop_test();
	end
endmodule
